// ===== vdst_pkg.sv
// Package with register map, field layout and constants of the display status tracker.
package vdst_pkg;

   // ********************************************
   // Register offsets (byte addresses)
   // ********************************************
   localparam logic [11:0] VDST_ADDR_STATUS = 12'h200;
   localparam logic [11:0] VDST_ADDR_IRQ_STATUS = 12'h300;
   localparam logic [11:0] VDST_ADDR_IRQ_MASK = 12'h304;
   localparam logic [11:0] VDST_ADDR_CONTROL = 12'h308;

   // ********************************************
   // Status register field layout
   // ********************************************
   localparam int VDST_FRAME_DONE_FLAG_BIT = 30;
   localparam int VDST_F2D_BIT = 29;
   localparam int VDST_F1D_BIT = 28;
   localparam int VDST_LINE_LSB = 16;
   localparam int VDST_VBLANK_BIT = 13;
   localparam int VDST_FIELD_BIT = 12;
   localparam int VDST_PIXEL_LSB = 0;
   localparam int VDST_CNT_W = 12;

   // ********************************************
   // Interrupt status and mask layout
   // ********************************************
   localparam int VDST_IRQ_DISPLAY_COMPLETE_IRQ_BIT = 0;
   localparam int VDST_IRQ_COMPLETION_NOT_ACKED_IRQ_BIT = 1;
   localparam int VDST_IRQ_W = 2;

   // ********************************************
   // Control register layout
   // ********************************************
   localparam int VDST_CTL_CON_BIT = 0;
   localparam int VDST_CTL_W = 1;

   // ********************************************
   // Status reset value and unmapped read data
   // ********************************************
   localparam logic [31:0] VDST_STATUS_RST = 32'h0000_0000;
   localparam logic [31:0] VDST_UNMAPPED_DATA = 32'h0000_0000;

endpackage : vdst_pkg

// ===== vdst_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module vdst_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] q_r;
   logic [WIDTH-1:0] q_nxt;

   always_comb begin
      q_nxt = q_r;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            q_nxt[i] = s3_r[i];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_r <= '0;
      end else begin
         s1_r <= d_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r <= q_nxt;
      end
   end

   assign q_o = q_r;
endmodule : vdst_sync
`default_nettype wire

// ===== vdst_top.sv
// Display status tracker: status register, completion flags and interrupts over APB.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module vdst_top
   import vdst_pkg::*;
#(
   parameter int CNT_W = VDST_CNT_W
) (
   input wire logic REF_CLK_I,
   input wire logic SRST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic [CNT_W-1:0] FRAME_LINE_COUNTER_I,
   input wire logic [CNT_W-1:0] FRAME_PIXEL_COUNTER_I,
   input wire logic VBLANK_I,
   input wire logic FIELD2_I,
   input wire logic LAST_PIXEL_PAD_I,
   input wire logic FIELD1_END_I,
   input wire logic FIELD2_END_I,
   input wire logic FRAME_END_I,
   output logic IRQ_O
);

   // ********************************************
   // Display engine inputs
   // ********************************************
   logic [CNT_W-1:0] line_r;
   logic [CNT_W-1:0] line_nxt;
   logic [CNT_W-1:0] pixel_r;
   logic [CNT_W-1:0] pixel_nxt;
   logic vblank_r;
   logic vblank_nxt;
   logic field_r;
   logic field_nxt;
   logic vblank_d_r;
   logic vblank_d_nxt;
   logic [2:0] ev_sync;
   logic pad_lvl_d_r;
   logic pad_lvl_d_nxt;
   logic pad_evt;

   // The pad, blanking and field levels come from the display clock pins, so they are synchronised.
   vdst_sync #(
      .WIDTH(3)
   ) u_sync (
      .clk_i(REF_CLK_I),
      .srst_i(SRST_I),
      .d_i({LAST_PIXEL_PAD_I, VBLANK_I, FIELD2_I}),
      .q_o(ev_sync)
   );

   // Completion fires once on the rising edge of the last-pixel-at-pad level.
   assign pad_evt = ev_sync[2] & ~pad_lvl_d_r;

   always_comb begin
      line_nxt = FRAME_LINE_COUNTER_I;
      pixel_nxt = FRAME_PIXEL_COUNTER_I;
      vblank_nxt = ev_sync[1];
      vblank_d_nxt = ev_sync[1];
      pad_lvl_d_nxt = ev_sync[2];
      field_nxt = field_r;
      // Field indicator follows the engine only as a new blanking interval opens.
      if (ev_sync[1] && !vblank_d_r) begin
         field_nxt = ev_sync[0];
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         line_r <= '0;
         pixel_r <= '0;
         vblank_r <= 1'b0;
         vblank_d_r <= 1'b0;
         field_r <= 1'b0;
         pad_lvl_d_r <= 1'b0;
      end else begin
         line_r <= line_nxt;
         pixel_r <= pixel_nxt;
         vblank_r <= vblank_nxt;
         vblank_d_r <= vblank_d_nxt;
         field_r <= field_nxt;
         pad_lvl_d_r <= pad_lvl_d_nxt;
      end
   end

   // ********************************************
   // APB decode
   // ********************************************
   logic apb_wr;
   logic apb_rd;
   logic sel_status;
   logic sel_irq_status;
   logic sel_irq_mask;
   logic sel_control;
   logic sel_any;

   assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
   assign apb_rd = PSEL_I & ~PENABLE_I & ~PWRITE_I;

   always_comb begin
      sel_status = 1'b0;
      sel_irq_status = 1'b0;
      sel_irq_mask = 1'b0;
      sel_control = 1'b0;
      if (PADDR_I == VDST_ADDR_STATUS) begin
         sel_status = 1'b1;
      end else if (PADDR_I == VDST_ADDR_IRQ_STATUS) begin
         sel_irq_status = 1'b1;
      end else if (PADDR_I == VDST_ADDR_IRQ_MASK) begin
         sel_irq_mask = 1'b1;
      end else if (PADDR_I == VDST_ADDR_CONTROL) begin
         sel_control = 1'b1;
      end
      sel_any = sel_status | sel_irq_status | sel_irq_mask | sel_control;
   end

   // ********************************************
   // Completion flags and interrupts
   // ********************************************
   logic f1d_r;
   logic f1d_nxt;
   logic f2d_r;
   logic f2d_nxt;
   logic frame_done_flag_r;
   logic frame_done_flag_nxt;
   logic [VDST_IRQ_W-1:0] irq_stat_r;
   logic [VDST_IRQ_W-1:0] irq_stat_nxt;
   logic [VDST_IRQ_W-1:0] irq_mask_r;
   logic [VDST_IRQ_W-1:0] irq_mask_nxt;
   logic [VDST_CTL_W-1:0] ctl_r;
   logic [VDST_CTL_W-1:0] ctl_nxt;
   logic irq_r;
   logic irq_nxt;
   logic set_f1;
   logic set_f2;
   logic set_frm;
   logic any_done;
   logic not_acked;

   always_comb begin
      set_f1 = pad_evt & FIELD1_END_I;
      set_f2 = pad_evt & FIELD2_END_I;
      set_frm = pad_evt & FRAME_END_I;
      any_done = set_f1 | set_f2 | set_frm;
      // In noncontinuous mode a new completion over an uncleared flag is a miss.
      not_acked = ~ctl_r[VDST_CTL_CON_BIT]
                  & ((set_f1 & f1d_r) | (set_f2 & f2d_r) | (set_frm & frame_done_flag_r));
      f1d_nxt = f1d_r;
      f2d_nxt = f2d_r;
      frame_done_flag_nxt = frame_done_flag_r;
      if (apb_wr && sel_status) begin
         // A one clears, a zero leaves the flag alone.
         if (PWDATA_I[VDST_F1D_BIT]) begin
            f1d_nxt = 1'b0;
         end
         if (PWDATA_I[VDST_F2D_BIT]) begin
            f2d_nxt = 1'b0;
         end
         if (PWDATA_I[VDST_FRAME_DONE_FLAG_BIT]) begin
            frame_done_flag_nxt = 1'b0;
         end
      end
      // Setting wins over a clear in the same cycle.
      if (set_f1) begin
         f1d_nxt = 1'b1;
      end
      if (set_f2) begin
         f2d_nxt = 1'b1;
      end
      if (set_frm) begin
         frame_done_flag_nxt = 1'b1;
      end
      irq_stat_nxt = irq_stat_r;
      if (apb_rd && sel_irq_status) begin
         irq_stat_nxt = '0;
      end
      if (any_done) begin
         irq_stat_nxt[VDST_IRQ_DISPLAY_COMPLETE_IRQ_BIT] = 1'b1;
      end
      if (not_acked) begin
         irq_stat_nxt[VDST_IRQ_COMPLETION_NOT_ACKED_IRQ_BIT] = 1'b1;
      end
      irq_mask_nxt = irq_mask_r;
      ctl_nxt = ctl_r;
      if (apb_wr && sel_irq_mask) begin
         irq_mask_nxt = PWDATA_I[VDST_IRQ_W-1:0];
      end
      if (apb_wr && sel_control) begin
         ctl_nxt = PWDATA_I[VDST_CTL_W-1:0];
      end
      irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         f1d_r <= 1'b0;
         f2d_r <= 1'b0;
         frame_done_flag_r <= 1'b0;
         irq_stat_r <= '0;
         irq_mask_r <= '0;
         ctl_r <= '0;
         irq_r <= 1'b0;
      end else begin
         f1d_r <= f1d_nxt;
         f2d_r <= f2d_nxt;
         frame_done_flag_r <= frame_done_flag_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         ctl_r <= ctl_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ********************************************
   // APB read path
   // ********************************************
   logic [31:0] status_word;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic pready_r;
   logic pready_nxt;
   logic pslverr_r;
   logic pslverr_nxt;

   always_comb begin
      status_word = VDST_STATUS_RST;
      status_word[VDST_FRAME_DONE_FLAG_BIT] = frame_done_flag_r;
      status_word[VDST_F2D_BIT] = f2d_r;
      status_word[VDST_F1D_BIT] = f1d_r;
      status_word[VDST_LINE_LSB +: VDST_CNT_W] = VDST_CNT_W'(line_r);
      status_word[VDST_VBLANK_BIT] = vblank_r;
      status_word[VDST_FIELD_BIT] = field_r;
      status_word[VDST_PIXEL_LSB +: VDST_CNT_W] = VDST_CNT_W'(pixel_r);
   end

   // Setup cycle loads the answer; access phase sees pready high, one wait-free cycle.
   always_comb begin
      prdata_nxt = prdata_r;
      pready_nxt = PSEL_I & ~PENABLE_I;
      pslverr_nxt = 1'b0;
      if (PSEL_I && !PENABLE_I) begin
         pslverr_nxt = ~sel_any;
         prdata_nxt = VDST_UNMAPPED_DATA;
         if (!PWRITE_I) begin
            if (sel_status) begin
               prdata_nxt = status_word;
            end else if (sel_irq_status) begin
               prdata_nxt = 32'(irq_stat_r);
            end else if (sel_irq_mask) begin
               prdata_nxt = 32'(irq_mask_r);
            end else if (sel_control) begin
               prdata_nxt = 32'(ctl_r);
            end
         end
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         prdata_r <= '0;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign PRDATA_O = prdata_r;
   assign PREADY_O = pready_r;
   assign PSLVERR_O = pslverr_r;
   assign IRQ_O = irq_r;

endmodule : vdst_top
`default_nettype wire

// ===== vdst_top_assertions.sv
// Checker of bus answers, status fields and interrupt of the status tracker.
`timescale 1ns/1ps
`default_nettype none
module vdst_top_assertions
   import vdst_pkg::*;
#(
   parameter int CNT_W = VDST_CNT_W
) (
   input wire logic REF_CLK_I,
   input wire logic SRST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   input wire logic [CNT_W-1:0] FRAME_LINE_COUNTER_I,
   input wire logic [CNT_W-1:0] FRAME_PIXEL_COUNTER_I,
   input wire logic VBLANK_I,
   input wire logic FIELD2_I,
   input wire logic LAST_PIXEL_PAD_I,
   input wire logic FIELD1_END_I,
   input wire logic FIELD2_END_I,
   input wire logic FRAME_END_I,
   input wire logic IRQ_O
);
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (SRST_I);
   logic [1:0] mask_r;
   logic [1:0] mask_nxt;
   wire logic acc = PSEL_I && PENABLE_I && PREADY_O;
   wire logic rd_st = PREADY_O && !PWRITE_I && PADDR_I == VDST_ADDR_STATUS;
   wire logic mapped = PADDR_I inside {VDST_ADDR_STATUS, VDST_ADDR_IRQ_STATUS,
      VDST_ADDR_IRQ_MASK, VDST_ADDR_CONTROL};
   // Tracks the interrupt mask as software writes it.
   always_comb begin
      mask_nxt = mask_r;
      if (acc && PWRITE_I && PADDR_I == VDST_ADDR_IRQ_MASK) begin
         mask_nxt = PWDATA_I[1:0];
      end
   end
   always_ff @(posedge REF_CLK_I) begin
      mask_r <= SRST_I ? 2'h0 : mask_nxt;
   end
   sequence px_still;
      $stable(FRAME_PIXEL_COUNTER_I) [*3];
   endsequence
   sequence ln_still;
      $stable(FRAME_LINE_COUNTER_I) [*3];
   endsequence
   sequence done_ev;
      $rose(LAST_PIXEL_PAD_I) && (FIELD1_END_I || FIELD2_END_I || FRAME_END_I);
   endsequence
   chk_answer_after_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
      else $error("no answer after setup");
   chk_reserved_zero: assert property (rd_st |-> PRDATA_O[31] == 0 && PRDATA_O[15:14] == 0)
      else $error("reserved status bits not zero");
   chk_pixel_value: assert property (px_still ##0 rd_st |-> PRDATA_O[11:0] == FRAME_PIXEL_COUNTER_I)
      else $error("pixel field wrong");
   chk_line_value: assert property (ln_still ##0 rd_st |-> PRDATA_O[27:16] == FRAME_LINE_COUNTER_I)
      else $error("line field wrong");
   chk_vblank_value: assert property ($stable(VBLANK_I) [*8] ##0 rd_st |-> PRDATA_O[13] == VBLANK_I)
      else $error("blanking bit wrong");
   chk_unmapped_err: assert property (PREADY_O && !mapped |-> PSLVERR_O && PRDATA_O == 0)
      else $error("unmapped access not refused");
   chk_irq_masked: assert property ($past(mask_r) == 0 && mask_r == 0 |-> !IRQ_O)
      else $error("interrupt while masked");
   chk_irq_raise: assert property (done_ev and mask_r[0] |-> ##[2:12] IRQ_O)
      else $error("completion raised no interrupt");
   chk_quiet_reset: assert property ($past(SRST_I) |-> !IRQ_O && !PREADY_O)
      else $error("outputs active after reset");
endmodule : vdst_top_assertions
bind vdst_top vdst_top_assertions #(.CNT_W(CNT_W)) vdst_top_assertions_inst (
   .REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .FRAME_LINE_COUNTER_I(FRAME_LINE_COUNTER_I),
   .FRAME_PIXEL_COUNTER_I(FRAME_PIXEL_COUNTER_I), .VBLANK_I(VBLANK_I), .FIELD2_I(FIELD2_I),
   .LAST_PIXEL_PAD_I(LAST_PIXEL_PAD_I), .FIELD1_END_I(FIELD1_END_I),
   .FIELD2_END_I(FIELD2_END_I), .FRAME_END_I(FRAME_END_I), .IRQ_O(IRQ_O));
`default_nettype wire

// ===== vdst_top_test.sv
// Self-checking bench of the display status tracker.
`timescale 1ns/1ps
`default_nettype none
module vdst_top_test
   import vdst_pkg::*;
;
   logic clk, srst, psel, pen, pwr, pready, pslverr, vbl, fld2, lpp, f1e, f2e, fre, irq, er;
   logic [11:0] paddr, line, pix;
   logic [31:0] pwdata, prdata, rd;
   int failures = 0;
   int n_checks = 0;
   vdst_top vdst_top_inst (.REF_CLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .FRAME_LINE_COUNTER_I(line),
      .FRAME_PIXEL_COUNTER_I(pix), .VBLANK_I(vbl), .FIELD2_I(fld2), .LAST_PIXEL_PAD_I(lpp),
      .FIELD1_END_I(f1e), .FIELD2_END_I(f2e), .FRAME_END_I(fre), .IRQ_O(irq));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task test_done;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk("pready", 32'h1, {31'h0, pready});
         test_done();
      end else begin
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         pen <= 1'b0;
      end
   endtask : apb
   task rdchk(input string name, input logic [11:0] a, input logic [31:0] m, e);
      apb(1'b0, a, 32'h0);
      chk(name, e, rd & m);
      chk("mapped slverr", 32'h0, {31'h0, er});
   endtask : rdchk
   // Signals one completion; the qualifier is held well around the pad pulse.
   task ev(input int k);
      @(posedge clk);
      {f1e, f2e, fre} <= {k == 0, k == 1, k == 2};
      @(posedge clk);
      lpp <= 1'b1;
      repeat (4) @(posedge clk);
      lpp <= 1'b0;
      repeat (6) @(posedge clk);
      {f1e, f2e, fre} <= 3'h0;
      repeat (3) @(posedge clk);
   endtask : ev
   task t_reset;
      rdchk("status", VDST_ADDR_STATUS, 32'hffffffff, VDST_STATUS_RST);
      rdchk("irq status", VDST_ADDR_IRQ_STATUS, 32'h3, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
   endtask : t_reset
   task t_fields;
      pix <= 12'hfff;
      line <= 12'habc;
      vbl <= 1'b1;
      apb(1'b1, VDST_ADDR_STATUS, 32'hffffffff);
      repeat (10) @(posedge clk);
      rdchk("status", VDST_ADDR_STATUS, 32'hffffffff, 32'h0abc_2fff);
      pix <= 12'h001;
      line <= 12'h000;
      vbl <= 1'b0;
      repeat (10) @(posedge clk);
      rdchk("status", VDST_ADDR_STATUS, 32'hffffffff, 32'h0000_0001);
   endtask : t_fields
   task t_field;
      fld2 <= 1'b1;
      repeat (10) @(posedge clk);
      rdchk("field", VDST_ADDR_STATUS, 32'h1000, 32'h0);
      vbl <= 1'b1;
      repeat (10) @(posedge clk);
      rdchk("field", VDST_ADDR_STATUS, 32'h1000, 32'h1000);
      fld2 <= 1'b0;
      vbl <= 1'b0;
      repeat (10) @(posedge clk);
      rdchk("field", VDST_ADDR_STATUS, 32'h1000, 32'h1000);
      vbl <= 1'b1;
      repeat (10) @(posedge clk);
      rdchk("field", VDST_ADDR_STATUS, 32'h1000, 32'h0);
      vbl <= 1'b0;
   endtask : t_field
   task t_done;
      logic [31:0] b;
      apb(1'b1, VDST_ADDR_IRQ_MASK, 32'h3);
      for (int k = 0; k < 3; k++) begin
         b = 32'h1 << (VDST_F1D_BIT + k);
         ev(k);
         rdchk("flag", VDST_ADDR_STATUS, 32'h7000_0000, b);
         chk("irq", 32'h1, {31'h0, irq});
         apb(1'b1, VDST_ADDR_STATUS, 32'h0);
         rdchk("flag", VDST_ADDR_STATUS, 32'h7000_0000, b);
         apb(1'b1, VDST_ADDR_STATUS, b);
         rdchk("flag", VDST_ADDR_STATUS, 32'h7000_0000, 32'h0);
         rdchk("irq status", VDST_ADDR_IRQ_STATUS, 32'h3, 32'h1);
         rdchk("irq status", VDST_ADDR_IRQ_STATUS, 32'h3, 32'h0);
         chk("irq", 32'h0, {31'h0, irq});
      end
   endtask : t_done
   task t_nack;
      for (int c = 0; c < 2; c++) begin
         apb(1'b1, VDST_ADDR_CONTROL, c);
         ev(0);
         ev(0);
         rdchk("irq status", VDST_ADDR_IRQ_STATUS, 32'h3, c ? 32'h1 : 32'h3);
         apb(1'b1, VDST_ADDR_STATUS, 32'h1000_0000);
      end
      apb(1'b1, VDST_ADDR_IRQ_MASK, 32'h0);
      ev(2);
      chk("masked irq", 32'h0, {31'h0, irq});
   endtask : t_nack
   task t_unmapped;
      apb(1'b1, 12'h3fc, 32'hffffffff);
      chk("slverr", 32'h1, {31'h0, er});
      apb(1'b0, 12'h3fc, 32'h0);
      chk("slverr", 32'h1, {31'h0, er});
      chk("unmapped data", VDST_UNMAPPED_DATA, rd);
   endtask : t_unmapped
   initial begin
      {srst, psel, pen, pwr, vbl, fld2, lpp, f1e, f2e, fre} = 10'h200;
      {paddr, line, pix, pwdata} = '0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_fields();
      t_field();
      t_done();
      t_nack();
      t_unmapped();
      test_done();
   end
endmodule : vdst_top_test
`default_nettype wire
